// ---- adc_cmd_pkg.sv ----
// constants, field layouts and types shared by the frame command decoder
package adc_cmd_pkg;

   // frame geometry
   localparam int          FRAME_BITS         = 16;
   localparam int          CMD_MSB            = 15;
   localparam int          CMD_LSB            = 12;

   // top-nibble command codes
   localparam logic [3:0]  CMD_CONTINUE       = 4'h0;
   localparam logic [3:0]  CMD_COUNT_SCAN     = 4'h3;
   localparam logic [3:0]  CMD_PIN_FUNCTION   = 4'h4;
   localparam logic [3:0]  CMD_LAST_CHANNEL   = 4'h9;
   localparam logic [1:0]  ALARM_PREFIX       = 2'h3;

   // count-scan mode frame fields
   localparam int          MODE_PROG_EN_BIT   = 11;
   localparam int          RANGE_BIT          = 6;
   localparam int          POWER_DOWN_BIT     = 5;
   localparam int          OUT_SEL_BIT        = 4;
   localparam int          GENERAL_OUT_MSB    = 3;

   // last-channel program fields
   localparam int          LAST_CH_MSB        = 9;
   localparam int          LAST_CH_LSB        = 6;

   // pin function program fields
   localparam int          SOFT_RESET_BIT     = 9;
   localparam int          PIN_FN_MSB         = 9;

   // alarm threshold frame fields
   localparam int          ALARM_GROUP_MSB    = 13;
   localparam int          ALARM_GROUP_LSB    = 12;
   localparam int          CHAN_IN_GROUP_MSB  = 15;
   localparam int          CHAN_IN_GROUP_LSB  = 14;
   localparam int          ALARM_HIGH_BIT     = 13;
   localparam int          ALARM_EXIT_BIT     = 12;
   localparam int          THRESH_MSB         = 9;

   // alarm pin assignments
   localparam logic [2:0]  ALARM_HIGH_PIN0    = 3'h2;
   localparam logic [2:0]  ALARM_LOW_PIN1     = 3'h4;
   localparam logic [2:0]  ALARM_SPLIT_PINS   = 3'h6;

   // reset values
   localparam logic [3:0]  LAST_CHANNEL_RESET = 4'hf;
   localparam logic [9:0]  HIGH_THRESH_RESET  = 10'h3ff;
   localparam logic [9:0]  LOW_THRESH_RESET   = 10'h000;
   localparam logic [3:0]  CHANNEL_RESET      = 4'h0;

   typedef struct packed {
      logic       soft_reset;
      logic       power_down_fn;
      logic       range_fn;
      logic [2:0] alarm_cfg;
      logic [3:0] dir;
   } pin_function_t;

   localparam pin_function_t PIN_FUNCTION_RESET = 10'h000;

   typedef struct packed {
      logic       range_2x;
      logic       power_down;
      logic       gpio_on_output;
      logic [3:0] general_output;
   } mode_settings_t;

   localparam mode_settings_t MODE_SETTINGS_RESET = 7'h00;

   typedef enum logic [1:0] {
      MODE_HOLD       = 2'b01,
      MODE_COUNT_SCAN = 2'b10
   } scan_mode_t;

   typedef enum logic [1:0] {
      PROG_IDLE  = 2'b01,
      PROG_ALARM = 2'b10
   } prog_state_t;

endpackage

// ---- adc_frame_command_decoder.sv ----
// frame command decoder: mode, last channel, pin functions and alarm thresholds
module adc_frame_command_decoder
   import adc_cmd_pkg::*;
#(
   parameter int GPIO_PINS = 4
) (
   input  wire logic        i_ref_clk,
   input  wire logic        i_rst,
   input  wire logic        i_link_sclk,
   input  wire logic        i_frame_select_n,
   input  wire logic        i_serial_in_bit,
   input  wire logic [11:0] i_conv_result,
   input  wire logic        i_result_valid,
   input  wire logic [3:0]  i_gpio_in,
   output logic             o_serial_out,
   output logic [3:0]       o_gpio_out,
   output logic [3:0]       o_gpio_oe,
   output logic [3:0]       o_channel,
   output logic             o_range_2x,
   output logic             o_power_down,
   output logic             o_alarm_high,
   output logic             o_alarm_low
);

   if (GPIO_PINS != 4) begin : g_pin_check
      $error("decoder serves exactly four pins");
   end

   function automatic logic [3:0] next_scan_channel(input logic [3:0] ch,
                                                   input logic [3:0] last);
      next_scan_channel = (ch == last) ? 4'h0 : ch + 4'h1;
   endfunction

   logic [15:0]    frame_word;
   logic           frame_toggle;
   logic [15:0]    tx_word_reg;
   logic [2:0]     toggle_sync_reg;
   logic [2:0]     select_sync_reg;
   logic [3:0]     gpio_meta_reg;
   logic [3:0]     gpio_sync_reg;
   logic           frame_done;
   logic           frame_start;
   logic [3:0]     cmd;
   scan_mode_t     mode_reg;
   prog_state_t    prog_reg;
   logic [1:0]     group_reg;
   logic [3:0]     last_channel_reg;
   pin_function_t  pin_fn_reg;
   mode_settings_t settings_reg;
   logic [3:0]     gpo_pin_reg;
   logic           soft_reset_pend_reg;
   logic           scan_restart;
   logic           thresh_wr;
   logic [9:0]     rd_high;
   logic [9:0]     rd_low;
   logic           pin0_alarm_fn;
   logic           pin1_alarm_fn;
   logic [3:0]     special_fn;
   logic [3:0]     pin_value;

   // link front end on the link clock
   frame_link u_link (
      .i_rst            (i_rst),
      .i_link_sclk      (i_link_sclk),
      .i_frame_select_n (i_frame_select_n),
      .i_serial_in_bit  (i_serial_in_bit),
      .i_tx_word        (tx_word_reg),
      .o_serial_out     (o_serial_out),
      .o_frame_word     (frame_word),
      .o_frame_toggle   (frame_toggle)
   );

   // crossings: toggle and select through two flops, third flop for edges
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         toggle_sync_reg <= 3'h0;
         select_sync_reg <= 3'h7;
         gpio_meta_reg   <= 4'h0;
         gpio_sync_reg   <= 4'h0;
      end else begin
         toggle_sync_reg <= {toggle_sync_reg[1:0], frame_toggle};
         select_sync_reg <= {select_sync_reg[1:0], i_frame_select_n};
         gpio_meta_reg   <= i_gpio_in;
         gpio_sync_reg   <= gpio_meta_reg;
      end
   end

   // frame word is static long after its toggle, safe to read here
   assign frame_done  = toggle_sync_reg[2] ^ toggle_sync_reg[1];
   assign frame_start = select_sync_reg[2] & ~select_sync_reg[1];
   assign cmd         = frame_word[CMD_MSB:CMD_LSB];

   // restart on any count-scan frame or on a last-channel write while scanning
   // scan restart causes
   assign scan_restart = frame_done && prog_reg == PROG_IDLE &&
                         (cmd == CMD_COUNT_SCAN ||
                          (cmd == CMD_LAST_CHANNEL && mode_reg == MODE_COUNT_SCAN));

   // program sequence state, alarm frames swallow all decoding
   // alarm sequence entry
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         prog_reg  <= PROG_IDLE;
         group_reg <= 2'h0;
      end else if (frame_start && soft_reset_pend_reg) begin
         prog_reg  <= PROG_IDLE;
         group_reg <= 2'h0;
      end else if (frame_done) begin
         unique case (prog_reg)
            PROG_IDLE: begin
               if (cmd[3:2] == ALARM_PREFIX) begin
                  prog_reg  <= PROG_ALARM;
                  group_reg <= frame_word[ALARM_GROUP_MSB:ALARM_GROUP_LSB];
               end
            end
            // exit only when the host asks, even after eight writes
            PROG_ALARM: begin
               if (frame_word[ALARM_EXIT_BIT]) begin
                  prog_reg <= PROG_IDLE;
               end
            end
         endcase
      end
   end

   // scan mode and last channel
   // last channel capture
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         mode_reg         <= MODE_HOLD;
         last_channel_reg <= LAST_CHANNEL_RESET;
      end else if (frame_start && soft_reset_pend_reg) begin
         mode_reg         <= MODE_HOLD;
         last_channel_reg <= LAST_CHANNEL_RESET;
      end else if (frame_done && prog_reg == PROG_IDLE) begin
         if (cmd == CMD_COUNT_SCAN) begin
            mode_reg <= MODE_COUNT_SCAN;
         end
         if (cmd == CMD_LAST_CHANNEL) begin
            last_channel_reg <= frame_word[LAST_CH_MSB:LAST_CH_LSB];
         end
      end
   end

   // channel counter, every frame except a scan restart advances while scanning
   // count scan stepping
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_channel <= CHANNEL_RESET;
      end else if (frame_start && soft_reset_pend_reg) begin
         o_channel <= CHANNEL_RESET;
      end else if (scan_restart) begin
         o_channel <= CHANNEL_RESET;
      end else if (frame_done && mode_reg == MODE_COUNT_SCAN) begin
         o_channel <= next_scan_channel(o_channel, last_channel_reg);
      end
   end

   // mode settings, taken only from an enabled count-scan frame
   // locked during alarm sequence
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         settings_reg <= MODE_SETTINGS_RESET;
      end else if (frame_start && soft_reset_pend_reg) begin
         settings_reg <= MODE_SETTINGS_RESET;
      end else if (frame_done && prog_reg == PROG_IDLE && cmd == CMD_COUNT_SCAN &&
                   frame_word[MODE_PROG_EN_BIT]) begin
         settings_reg.range_2x       <= frame_word[RANGE_BIT];
         settings_reg.power_down     <= frame_word[POWER_DOWN_BIT];
         settings_reg.gpio_on_output <= frame_word[OUT_SEL_BIT];
         settings_reg.general_output <= frame_word[GENERAL_OUT_MSB:0];
      end
   end

   // pin function register, reserved bits 11..10 are not stored
   // pin function write
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         pin_fn_reg          <= PIN_FUNCTION_RESET;
         soft_reset_pend_reg <= 1'b0;
      end else if (frame_start && soft_reset_pend_reg) begin
         pin_fn_reg          <= PIN_FUNCTION_RESET;
         soft_reset_pend_reg <= 1'b0;
      end else if (frame_done && prog_reg == PROG_IDLE && cmd == CMD_PIN_FUNCTION) begin
         pin_fn_reg            <= frame_word[PIN_FN_MSB:0];
         pin_fn_reg.soft_reset <= 1'b0;
         soft_reset_pend_reg   <= frame_word[SOFT_RESET_BIT];
      end
   end

   // output pins refresh only as the next frame opens
   // deferred output refresh
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         gpo_pin_reg <= 4'h0;
      end else if (frame_start) begin
         gpo_pin_reg <= soft_reset_pend_reg ? 4'h0 : settings_reg.general_output;
      end
   end

   // reply word loaded at select fall, fixed for the rest of the frame
   // straight binary result
   // input pins sampled at frame open
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         tx_word_reg <= 16'h0000;
      end else if (frame_start) begin
         tx_word_reg <= {settings_reg.gpio_on_output ? gpio_sync_reg : o_channel,
                         i_conv_result};
      end
   end

   // threshold write from alarm data frames
   // channel from group and frame bits
   // any count of writes before exit
   assign thresh_wr = frame_done && prog_reg == PROG_ALARM;

   threshold_mem #(
      .ADDR_W (4),
      .DATA_W (10)
   ) u_thresh (
      .i_ref_clk (i_ref_clk),
      .i_rst     (i_rst),
      .i_clear   (frame_start && soft_reset_pend_reg),
      .i_wr_en   (thresh_wr),
      .i_wr_high (frame_word[ALARM_HIGH_BIT]),
      .i_wr_addr ({group_reg, frame_word[CHAN_IN_GROUP_MSB:CHAN_IN_GROUP_LSB]}),
      .i_wr_data (frame_word[THRESH_MSB:0]),
      .i_rd_addr (o_channel),
      .o_rd_high (rd_high),
      .o_rd_low  (rd_low)
   );

   // alarm compare on the top ten result bits, held until the next result
   // threshold compare
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_alarm_high <= 1'b0;
         o_alarm_low  <= 1'b0;
      end else if (i_result_valid) begin
         o_alarm_high <= i_conv_result[11:2] > rd_high;
         o_alarm_low  <= i_conv_result[11:2] < rd_low;
      end
   end

   // alarm pin assignment
   // alarm pin decode
   assign pin0_alarm_fn = pin_fn_reg.alarm_cfg[0] ||
                          pin_fn_reg.alarm_cfg == ALARM_HIGH_PIN0 ||
                          pin_fn_reg.alarm_cfg == ALARM_SPLIT_PINS;
   assign pin1_alarm_fn = pin_fn_reg.alarm_cfg == ALARM_LOW_PIN1 ||
                          pin_fn_reg.alarm_cfg == ALARM_SPLIT_PINS;

   // special functions override direction bits
   // pin 3 and pin 2 inputs
   assign special_fn = {pin_fn_reg.power_down_fn, pin_fn_reg.range_fn,
                        pin1_alarm_fn, pin0_alarm_fn};
   assign pin_value  = {gpo_pin_reg[3:2], o_alarm_low,
                        pin_fn_reg.alarm_cfg[0] ? (o_alarm_high | o_alarm_low) :
                                                  o_alarm_high};
   assign o_gpio_oe  = {pin_fn_reg.dir[3:2] & ~special_fn[3:2],
                        pin1_alarm_fn | pin_fn_reg.dir[1],
                        pin0_alarm_fn | pin_fn_reg.dir[0]};
   assign o_gpio_out = {pin_value[3:2],
                        pin1_alarm_fn ? pin_value[1] : gpo_pin_reg[1],
                        pin0_alarm_fn ? pin_value[0] : gpo_pin_reg[0]};

   // range and power-down follow a pin when that function is chosen
   assign o_range_2x   = pin_fn_reg.range_fn ? gpio_sync_reg[2] : settings_reg.range_2x;
   assign o_power_down = pin_fn_reg.power_down_fn ? gpio_sync_reg[3] :
                         settings_reg.power_down;

   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);

   a_last_ch_store: assert property (
      frame_done && prog_reg == PROG_IDLE && cmd == CMD_LAST_CHANNEL && !frame_start
      |=> last_channel_reg == $past(frame_word[LAST_CH_MSB:LAST_CH_LSB]))
      else $error("last channel not stored");
   a_scan_wrap: assert property (
      frame_done && !scan_restart && !frame_start && mode_reg == MODE_COUNT_SCAN &&
      o_channel == last_channel_reg |=> o_channel == 4'h0)
      else $error("scan did not wrap to channel 0");
   a_scan_step: assert property (
      frame_done && !scan_restart && !frame_start && mode_reg == MODE_COUNT_SCAN &&
      o_channel != last_channel_reg |=> o_channel == $past(o_channel) + 4'h1)
      else $error("scan did not step by one");
   a_continue_keeps: assert property (
      frame_done && prog_reg == PROG_IDLE && cmd == CMD_CONTINUE && !frame_start
      |=> $stable(settings_reg) && $stable(pin_fn_reg) && $stable(mode_reg))
      else $error("continue frame changed settings");
   a_result_binary: assert property (
      frame_start |=> tx_word_reg[11:0] == $past(i_conv_result))
      else $error("result code altered");
   a_gpo_deferred: assert property (
      $changed(gpo_pin_reg) |-> $past(frame_start))
      else $error("output pins moved outside frame open");
   a_gpi_sampled: assert property (
      frame_start && settings_reg.gpio_on_output |=> tx_word_reg[15:12] == $past(gpio_sync_reg))
      else $error("input pins not in reply");
   a_prog_locks: assert property (
      prog_reg == PROG_ALARM && frame_done && !frame_start |=> $stable(settings_reg))
      else $error("settings changed during alarm sequence");
   a_soft_reset: assert property (
      frame_start && soft_reset_pend_reg |=> mode_reg == MODE_HOLD &&
      pin_fn_reg == PIN_FUNCTION_RESET && !soft_reset_pend_reg)
      else $error("soft reset not applied");
   a_alarm_exit: assert property (
      prog_reg == PROG_ALARM && frame_done && frame_word[ALARM_EXIT_BIT] |=> prog_reg == PROG_IDLE)
      else $error("alarm sequence not left");
   a_scan_restart: assert property (
      scan_restart && !frame_start |=> o_channel == 4'h0 && mode_reg == MODE_COUNT_SCAN)
      else $error("scan did not restart");

   c_scan_wrap: cover property (frame_done && mode_reg == MODE_COUNT_SCAN &&
                                o_channel == last_channel_reg);
   c_alarm_exit: cover property (prog_reg == PROG_ALARM ##1 prog_reg == PROG_IDLE);
   c_soft_reset: cover property (frame_start && soft_reset_pend_reg);
   c_pin_refresh: cover property ($changed(gpo_pin_reg));

endmodule

// ---- frame_link.sv ----
// serial link front end on the link clock: frame shift-in and result shift-out
module frame_link
   import adc_cmd_pkg::*;
(
   input  wire logic        i_rst,
   input  wire logic        i_link_sclk,
   input  wire logic        i_frame_select_n,
   input  wire logic        i_serial_in_bit,
   input  wire logic [15:0] i_tx_word,
   output logic             o_serial_out,
   output logic [15:0]      o_frame_word,
   output logic             o_frame_toggle
);

   logic        link_clear;
   logic [3:0]  bit_cnt_reg;
   logic [14:0] shift_reg;

   // select high clears the counter, the link clock may stop between frames
   assign link_clear = i_rst | i_frame_select_n;

   // bit counter and shifter, msb first
   // sixteen-clock frames
   always_ff @(posedge i_link_sclk or posedge link_clear) begin
      if (link_clear) begin
         bit_cnt_reg <= 4'h0;
         shift_reg   <= 15'h0000;
      end else begin
         bit_cnt_reg <= bit_cnt_reg + 4'h1;
         shift_reg   <= {shift_reg[13:0], i_serial_in_bit};
      end
   end

   // completed word held stable for a whole frame, toggle tells the core
   always_ff @(posedge i_link_sclk or posedge i_rst) begin
      if (i_rst) begin
         o_frame_word   <= 16'h0000;
         o_frame_toggle <= 1'b0;
      end else if (!i_frame_select_n && bit_cnt_reg == 4'hf) begin
         o_frame_word   <= {shift_reg, i_serial_in_bit};
         o_frame_toggle <= ~o_frame_toggle;
      end
   end

   // reply word is static for the frame once the core has loaded it
   assign o_serial_out = i_tx_word[4'hf - bit_cnt_reg];

endmodule

// ---- host_link_model.sv ----
// host side of the serial command link: frames words out, collects reply bits
module host_link_model (
   input  wire logic i_serial_out,
   output logic      o_sclk,
   output logic      o_select_n,
   output logic      o_sdi
);
   timeunit 1ns;
   timeprecision 1ps;
   // link idle: clock parked low, select high
   initial begin
      o_sclk     = 1'b0;
      o_select_n = 1'b1;
      o_sdi      = 1'b0;
   end
   // one frame; guard times let the core load its reply word
   // sixteen clocks, msb first
   // continue frames keep the line low
   // pin frames are sent with bits 11..10 at zero
   // the host sets the exit bit to leave alarm programming
   task automatic send(input logic [15:0] w, output logic [15:0] r);
      #100 o_select_n = 1'b0;
      #100;
      for (int i = 15; i >= 0; i--) begin
         o_sdi = w[i];
         r[i]  = i_serial_out;
         #80 o_sclk = 1'b1;
         #80 o_sclk = 1'b0;
      end
      // released line shows the inverse, not a stale level
      o_sdi = ~o_sdi;
      #40 o_select_n = 1'b1;
      #200;
   endtask
endmodule

// ---- tb_top.sv ----
// self-checking bench for the frame command decoder
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   `define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
      $display("[FAIL] %s expected %h seen %h", n, e, g); end end
   logic        i_ref_clk, i_rst, sclk, sel_n, sdi, valid, so, r2x, pd, ah, al;
   logic [11:0] res;
   logic [3:0]  gin, gout, goe, ch;
   logic [15:0] rx;
   int          error_cnt, comparisons;
   adc_frame_command_decoder adc_frame_command_decoder_inst (
      .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_link_sclk(sclk), .i_frame_select_n(sel_n),
      .i_serial_in_bit(sdi), .i_conv_result(res), .i_result_valid(valid), .i_gpio_in(gin),
      .o_serial_out(so), .o_gpio_out(gout), .o_gpio_oe(goe), .o_channel(ch),
      .o_range_2x(r2x), .o_power_down(pd), .o_alarm_high(ah), .o_alarm_low(al));
   host_link_model host_link_model_inst (
      .i_serial_out(so), .o_sclk(sclk), .o_select_n(sel_n), .o_sdi(sdi));
   // core clock, 100 MHz
   initial begin
      i_ref_clk = 1'b0;
      forever #5 i_ref_clk = ~i_ref_clk;
   end
   task automatic frame(input logic [15:0] w);
      host_link_model_inst.send(w, rx);
   endtask
   // one-cycle result pulse, then the alarm level has landed
   task automatic result(input logic [11:0] v);
      @(negedge i_ref_clk) res = v;
      repeat (3) @(negedge i_ref_clk);
      valid = 1'b1;
      @(negedge i_ref_clk) valid = 1'b0;
      @(negedge i_ref_clk);
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // hang guard, far beyond the seventeen frames of the run
   initial begin
      #500us;
      error_cnt++;
      report_and_stop();
   end
   initial begin
      i_rst = 1'b1; valid = 1'b0; res = 12'h000; gin = 4'ha;
      repeat (10) @(negedge i_ref_clk);
      i_rst = 1'b0;
      `CHK("reset channel", 4'h0, ch)
      `CHK("reset oe", 4'h0, goe)
      $display("test reset done");
      // last channel 2, all pins outputs, count scan with range 2x and outputs 5
      frame(16'h9080);
      frame(16'h400f);
      frame(16'h3845);
      `CHK("scan start", 4'h0, ch)
      `CHK("range bit", 1'b1, r2x)
      frame(16'h0000);
      // outputs reach pins at the next select fall
      `CHK("gpio out", 4'h5, gout)
      `CHK("gpio oe", 4'hf, goe)
      `CHK("scan 1", 4'h1, ch)
      frame(16'h0000);
      `CHK("scan 2", 4'h2, ch)
      frame(16'h0000);
      `CHK("scan wrap", 4'h0, ch)
      // output-select bit puts the synced input pins into the reply
      frame(16'h3810);
      `CHK("range cleared", 1'b0, r2x)
      frame(16'h0000);
      `CHK("input pins in reply", 4'ha, rx[15:12])
      $display("test count scan done");
      // soft reset lands at the next select fall
      frame(16'h4200);
      `CHK("scan before reset", 4'h2, ch)
      frame(16'h0000);
      `CHK("soft reset oe", 4'h0, goe)
      `CHK("soft reset channel", 4'h0, ch)
      frame(16'h0000);
      `CHK("hold channel", 4'h0, ch)
      $display("test soft reset done");
      // pin 3 power-down input, pin 2 range input, pin 0 high alarm output
      frame(16'h41a0);
      `CHK("power-down pin", 1'b1, pd)
      `CHK("range pin", 1'b0, r2x)
      `CHK("alarm pin oe", 4'h1, goe)
      $display("test pin functions done");
      // group 0: channel 0 low 080, then high 100 and exit in a frame coded like 0011
      frame(16'hc000);
      frame(16'h0080);
      frame(16'h3100);
      @(negedge i_ref_clk) res = 12'h7ff;
      frame(16'h0000);
      `CHK("alarm data not decoded", 4'h0, ch)
      frame(16'h0000);
      `CHK("reply word", 16'h07ff, rx)
      // top ten result bits against the channel 0 thresholds, pin 0 shows high only
      result(12'h404);
      `CHK("alarm high on", 1'b1, ah)
      `CHK("alarm pin high", 4'h1, gout)
      result(12'h403);
      `CHK("alarm high off", 1'b0, ah)
      `CHK("alarm low", 1'b0, al)
      result(12'h1fc);
      `CHK("alarm low on", 1'b1, al)
      `CHK("low alarm not on pin 0", 4'h0, gout)
      $display("test alarm done");
      report_and_stop();
   end
endmodule

// ---- threshold_mem.sv ----
// per-channel high and low alarm thresholds with registered read
module threshold_mem
   import adc_cmd_pkg::*;
#(
   parameter int ADDR_W = 4,
   parameter int DATA_W = 10
) (
   input  wire logic              i_ref_clk,
   input  wire logic              i_rst,
   input  wire logic              i_clear,
   input  wire logic              i_wr_en,
   input  wire logic              i_wr_high,
   input  wire logic [ADDR_W-1:0] i_wr_addr,
   input  wire logic [DATA_W-1:0] i_wr_data,
   input  wire logic [ADDR_W-1:0] i_rd_addr,
   output logic      [DATA_W-1:0] o_rd_high,
   output logic      [DATA_W-1:0] o_rd_low
);

   localparam int DEPTH = 1 << ADDR_W;

   if (DATA_W != 10) begin : g_width_check
      $error("threshold width must be 10");
   end

   logic [DATA_W-1:0] high_mem [DEPTH];
   logic [DATA_W-1:0] low_mem  [DEPTH];
   logic [DEPTH-1:0]  high_valid_reg;
   logic [DEPTH-1:0]  low_valid_reg;

   // storage has no reset, unwritten entries read as defaults instead
   always_ff @(posedge i_ref_clk) begin
      if (i_wr_en && i_wr_high) begin
         high_mem[i_wr_addr] <= i_wr_data;
      end
      if (i_wr_en && !i_wr_high) begin
         low_mem[i_wr_addr] <= i_wr_data;
      end
   end

   // written flags, cleared by reset or soft reset
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         high_valid_reg <= '0;
         low_valid_reg  <= '0;
      end else if (i_clear) begin
         high_valid_reg <= '0;
         low_valid_reg  <= '0;
      end else if (i_wr_en) begin
         high_valid_reg[i_wr_addr] <= high_valid_reg[i_wr_addr] | i_wr_high;
         low_valid_reg[i_wr_addr]  <= low_valid_reg[i_wr_addr] | ~i_wr_high;
      end
   end

   // registered read with default substitution
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_rd_high <= HIGH_THRESH_RESET;
         o_rd_low  <= LOW_THRESH_RESET;
      end else begin
         o_rd_high <= high_valid_reg[i_rd_addr] ? high_mem[i_rd_addr] : HIGH_THRESH_RESET;
         o_rd_low  <= low_valid_reg[i_rd_addr] ? low_mem[i_rd_addr] : LOW_THRESH_RESET;
      end
   end

endmodule
